//--- irq_ctrl_regs.svh
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
// register offsets on the special function register port
`define ENABLE_REG_ADDR    8'ha8
`define PRIORITY_REG_ADDR  8'hb8
`define STATUS_REG_ADDR    8'hb9
`define SERVICE_REG_ADDR   8'hba
// enable register fields
`define GLOBAL_GATE_BIT    7
`define TWOWIRE_BIT        6
`define TIMER2_BIT         5
`define UART_BIT           4
`define TIMER1_BIT         3
`define PIN1_BIT           2
`define TIMER0_BIT         1
`define PIN0_BIT           0
// reset values and priority write mask
`define ENABLE_RESET       8'h00
`define PRIORITY_RESET     8'h00
`define PRIORITY_MASK      8'h7f
// number of sources
`define NUM_SOURCES        7
`endif

//--- irq_ctrl_pkg.sv
`default_nettype none
package irq_ctrl_pkg;
    typedef enum logic [1:0] {
        svc_idle,
        svc_low,
        svc_high
    } svc_level_t;
    typedef logic [2:0] src_index_t;
endpackage
`default_nettype wire

//--- twowire_start_detect.sv
`default_nettype none
module twowire_start_detect (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // filtered bus lines
    input  wire logic scl_in,
    input  wire logic sda_in,
    // request
    output logic      start_req
);
    logic scl_q;
    logic sda_q;
    logic armed;

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // start: sda falls while scl high; request on next scl falling edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            armed     <= 1'b0;
            start_req <= 1'b0;
        end else begin
            start_req <= 1'b0;
            if (scl_q && scl_in && sda_q && !sda_in) begin
                armed <= 1'b1;
            end else if (armed && scl_q && !scl_in) begin
                armed     <= 1'b0;
                start_req <= 1'b1;
            end else if (scl_q && scl_in && !sda_q && sda_in) begin
                armed <= 1'b0;
            end
        end
    end

    start_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        start_req |-> $past(armed) && $past(scl_q) && !$past(scl_in))
        else $error("two-wire request without start and clock fall");
endmodule // twowire_start_detect
`default_nettype wire

//--- irq_ctrl.sv
`include "irq_ctrl_regs.svh"
`default_nettype none
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int NSRC = `NUM_SOURCES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // peripheral request levels
    input  wire logic        pin_irq0,
    input  wire logic        timer0_irq,
    input  wire logic        pin_irq1,
    input  wire logic        timer1_irq,
    input  wire logic        uart_irq,
    input  wire logic        timer2_irq,
    // two-wire bus lines, already filtered
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // cpu core side
    output logic             irq_req,
    output logic [2:0]       irq_src,
    output logic             irq_high,
    input  wire logic        irq_ack,
    input  wire logic        irq_ret
);
    logic [7:0]      interrupt_enable_reg;
    logic [7:0]      interrupt_priority_reg;
    logic            twowire_pending;
    logic            twowire_start;
    logic [NSRC-1:0] raw_req;
    logic [NSRC-1:0] enabled_req;
    logic [NSRC-1:0] level_bit;
    logic            low_active;
    logic            high_active;
    svc_level_t      svc_level;
    logic            next_req;
    logic [2:0]      next_src;
    logic            next_high;

    twowire_start_detect u_start (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .scl_in    (scl_in),
        .sda_in    (sda_in),
        .start_req (twowire_start)
    );

    // two-wire request is an event; held until the core takes it
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            twowire_pending <= 1'b0;
        end else if (twowire_start) begin
            twowire_pending <= 1'b1;
        end else if (irq_ack && irq_src == 3'(`TWOWIRE_BIT)) begin
            twowire_pending <= 1'b0;
        end
    end

    // source index equals enable bit position
    assign raw_req = {twowire_pending, timer2_irq, uart_irq, timer1_irq,
                      pin_irq1, timer0_irq, pin_irq0};

    // per-source enable and gate
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_src
            assign enabled_req[g] = raw_req[g] && interrupt_enable_reg[g]
                                    && interrupt_enable_reg[`GLOBAL_GATE_BIT];
            assign level_bit[g]   = interrupt_priority_reg[g];
        end
    endgenerate

    // register writes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            interrupt_enable_reg <= `ENABLE_RESET;
        end else if (reg_wr && reg_addr == `ENABLE_REG_ADDR) begin
            interrupt_enable_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            interrupt_priority_reg <= `PRIORITY_RESET;
        end else if (reg_wr && reg_addr == `PRIORITY_REG_ADDR) begin
            interrupt_priority_reg <= reg_wdata & `PRIORITY_MASK;
        end
    end

    // read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ENABLE_REG_ADDR:   reg_rdata <= interrupt_enable_reg;
                `PRIORITY_REG_ADDR: reg_rdata <= interrupt_priority_reg;
                `STATUS_REG_ADDR:   reg_rdata <= {1'b0, raw_req};
                `SERVICE_REG_ADDR:  reg_rdata <= {6'h00, high_active, low_active};
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // nesting: a low routine may be preempted by high, nothing preempts high
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            low_active  <= 1'b0;
            high_active <= 1'b0;
        end else if (irq_ack && irq_req) begin
            if (irq_high) begin
                high_active <= 1'b1;
            end else begin
                low_active <= 1'b1;
            end
        end else if (irq_ret) begin
            // return closes the innermost routine first
            if (high_active) begin
                high_active <= 1'b0;
            end else begin
                low_active <= 1'b0;
            end
        end
    end

    always_comb begin
        if (high_active) begin
            svc_level = svc_high;
        end else if (low_active) begin
            svc_level = svc_low;
        end else begin
            svc_level = svc_idle;
        end
    end

    // select: high level first, lowest index within a level
    always_comb begin
        next_req  = 1'b0;
        next_src  = 3'h0;
        next_high = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (enabled_req[i] && level_bit[i]) begin
                next_req  = 1'b1;
                next_src  = 3'(i);
                next_high = 1'b1;
            end
        end
        if (!next_req) begin
            for (int i = NSRC - 1; i >= 0; i--) begin
                if (enabled_req[i]) begin
                    next_req = 1'b1;
                    next_src = 3'(i);
                end
            end
        end
        case (svc_level)
            svc_high: next_req = 1'b0;
            svc_low:  next_req = next_req && next_high;
            default:  ;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            irq_req  <= 1'b0;
            irq_src  <= 3'h0;
            irq_high <= 1'b0;
        end else begin
            irq_req  <= next_req && !(irq_ack && irq_req);
            irq_src  <= next_src;
            irq_high <= next_high;
        end
    end

    gate_off_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !interrupt_enable_reg[7] |=> !irq_req)
        else $error("request passed with global gate closed");
    twowire_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_src == 3'h6 |-> $past(interrupt_enable_reg[6]))
        else $error("two-wire request passed while masked");
    uart_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_src == 3'h4 |-> $past(interrupt_enable_reg[4]))
        else $error("uart request passed while masked");
    pin0_mask_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_src == 3'h0 |-> $past(interrupt_enable_reg[0]))
        else $error("pin 0 request passed while masked");
    enable_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_wr && reg_addr == 8'ha8 |=> interrupt_enable_reg == $past(reg_wdata))
        else $error("enable register write lost");
    reserved_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        reg_rd && reg_addr == 8'hb8 |=> !reg_rdata[7])
        else $error("reserved priority bit read as one");
    twowire_level_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq_req && irq_src == 3'h6 |-> irq_high == $past(interrupt_priority_reg[6]))
        else $error("two-wire level does not follow its priority bit");
    no_preempt_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $past(high_active) |-> !irq_req)
        else $error("request raised during high level service");
    timer2_src_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        timer2_irq && interrupt_enable_reg == 8'ha0 && svc_level == svc_idle
        && !irq_ack && !irq_ret |=> irq_req && irq_src == 3'h5)
        else $error("timer 2 request not raised");
endmodule // irq_ctrl
`default_nettype wire

//--- core_model.sv
`default_nettype none
module core_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // offer from the controller
    input  wire logic irq_req,
    // bench controls
    input  wire logic ack_en,
    input  wire logic ret_go,
    // answers to the controller
    output logic      irq_ack,
    output logic      irq_ret
);
    timeunit 1ns;
    timeprecision 1ns;
    // one ack per offer: the offer drops right after it is taken
    always_ff @(posedge clk_sys) begin
        irq_ack <= resetn && ack_en && irq_req && !irq_ack;
        irq_ret <= resetn && ret_go;
    end
endmodule // core_model
`default_nettype wire

//--- mcu_interrupt_enable_priority_test.sv
`default_nettype none
module mcu_interrupt_enable_priority_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_sys = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
    logic       scl_in = 1'h1, sda_in = 1'h1, ack_en = 1'h0, ret_go = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, en, pr;
    logic [5:0] src = 6'h00, v;
    logic [2:0] irq_src, e_src;
    logic       irq_req, irq_high, irq_ack, irq_ret, e_req, e_hi;
    int         err_count = 0, samples_checked = 0;
    // enable, priority, sources, then expected request, index, level
    logic [26:0] rows [11] = '{
        {8'h82, 8'h00, 6'h02, 1'h1, 3'h1, 1'h0}, {8'h02, 8'h00, 6'h02, 1'h0, 3'h0, 1'h0},
        {8'h81, 8'h00, 6'h01, 1'h1, 3'h0, 1'h0}, {8'h84, 8'h00, 6'h04, 1'h1, 3'h2, 1'h0},
        {8'h88, 8'h00, 6'h08, 1'h1, 3'h3, 1'h0}, {8'h90, 8'h00, 6'h10, 1'h1, 3'h4, 1'h0},
        {8'ha0, 8'h00, 6'h20, 1'h1, 3'h5, 1'h0}, {8'hbf, 8'h00, 6'h3f, 1'h1, 3'h0, 1'h0},
        {8'hbf, 8'h20, 6'h3f, 1'h1, 3'h5, 1'h1}, {8'hdf, 8'h00, 6'h20, 1'h0, 3'h0, 1'h0},
        {8'h80, 8'h00, 6'h3f, 1'h0, 3'h0, 1'h0}};

    irq_ctrl uut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_irq0(src[0]), .timer0_irq(src[1]), .pin_irq1(src[2]), .timer1_irq(src[3]),
        .uart_irq(src[4]), .timer2_irq(src[5]), .scl_in(scl_in), .sda_in(sda_in),
        .irq_req(irq_req), .irq_src(irq_src), .irq_high(irq_high), .irq_ack(irq_ack),
        .irq_ret(irq_ret));
    core_model core (.clk_sys(clk_sys), .resetn(resetn), .irq_req(irq_req),
        .ack_en(ack_en), .ret_go(ret_go), .irq_ack(irq_ack), .irq_ret(irq_ret));

    always #10 clk_sys = ~clk_sys;

    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        chk("reg_rdata", reg_rdata, e);
    endtask
    // bounded wait: a missing offer is a mismatch and ends the run
    task automatic wait_req;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            #1;
            if (irq_req === 1'h1) return;
        end
        chk("irq_req", 8'(irq_req), 8'h01);
        finish_test();
    endtask
    task automatic offer(input logic [2:0] s, input logic h);
        wait_req();
        chk("irq_src", 8'(irq_src), 8'(s));
        chk("irq_high", 8'(irq_high), 8'(h));
    endtask
    task automatic idle_chk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
        chk("irq_req", 8'(irq_req), 8'h00);
    endtask
    task automatic ret;
        @(posedge clk_sys);
        ret_go <= 1'h1;
        @(posedge clk_sys);
        ret_go <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'h1;
        rd(8'ha8, 8'h00);
        rd(8'hb8, 8'h00);
        for (int r = 0; r < 11; r++) begin
            {en, pr, v, e_req, e_src, e_hi} = rows[r];
            wr(8'ha8, en);
            wr(8'hb8, pr);
            rd(8'ha8, en);
            @(posedge clk_sys);
            src <= v;
            repeat (3) @(posedge clk_sys);
            #1;
            chk("irq_req", 8'(irq_req), 8'(e_req));
            if (e_req) chk("irq_src", 8'(irq_src), 8'(e_src));
            if (e_req) chk("irq_high", 8'(irq_high), 8'(e_hi));
            @(posedge clk_sys);
            src <= 6'h00;
            repeat (2) @(posedge clk_sys);
        end
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h7f);
        wr(8'h10, 8'h55);
        rd(8'h10, 8'h00);
        rd(8'ha8, 8'h80);
        // nesting: low taken, high preempts, low held off until both return
        wr(8'ha8, 8'h8a);
        wr(8'hb8, 8'h08);
        @(posedge clk_sys);
        ack_en <= 1'h1;
        src <= 6'h02;
        offer(3'h1, 1'h0);
        idle_chk(3);
        @(posedge clk_sys);
        src <= 6'h0a;
        offer(3'h3, 1'h1);
        idle_chk(4);
        rd(8'hba, 8'h03);
        rd(8'hb9, 8'h0a);
        @(posedge clk_sys);
        src <= 6'h02;
        ret();
        idle_chk(3);
        ret();
        offer(3'h1, 1'h0);
        @(posedge clk_sys);
        src <= 6'h00;
        ret();
        // start condition then clock fall raises the two-wire request
        wr(8'ha8, 8'hc0);
        wr(8'hb8, 8'h40);
        @(posedge clk_sys);
        sda_in <= 1'h0;
        repeat (2) @(posedge clk_sys);
        scl_in <= 1'h0;
        offer(3'h6, 1'h1);
        ret();
        idle_chk(3);
        @(posedge clk_sys);
        scl_in <= 1'h1;
        @(posedge clk_sys);
        sda_in <= 1'h1;
        resetn <= 1'h0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'h1;
        rd(8'ha8, 8'h00);
        rd(8'hb8, 8'h00);
        finish_test();
    end
endmodule // mcu_interrupt_enable_priority_test
`default_nettype wire
